// ### include/asb_consts.vh
// Purpose: Constants for the converter selection buffer and sleep start control
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`ifndef ASB_CONSTS_VH
`define ASB_CONSTS_VH
`define ASB_OFS_SEL        4'h0
`define ASB_OFS_CTRL       4'h4
`define ASB_OFS_RESULT     4'h8
`define ASB_OFS_APPLIED    4'hC
`define ASB_CHAN_LSB       0
`define ASB_CHAN_MSB       4
`define ASB_REF_LSB        6
`define ASB_REF_MSB        7
`define ASB_CTL_EN         0
`define ASB_CTL_START      1
`define ASB_CTL_AUTO       2
`define ASB_CTL_FLAG       3
`define ASB_CTL_IE         4
`define ASB_CTL_PRE_LSB    8
`define ASB_CTL_PRE_MSB    10
`define ASB_REF_EXT        2'h0
`define ASB_REF_SUPPLY     2'h1
`define ASB_REF_INT_1V1    2'h2
`define ASB_REF_INT_2V56   2'h3
`define ASB_SLEEP_IDLE     3'h0
`define ASB_SLEEP_NOISE    3'h1
`define ASB_NORMAL_CYC     5'h0D
`define ASB_FIRST_CYC      5'h19
`define ASB_RES_MAX        10'h3FF
`define ASB_SETTLE_US      125
`endif

// ### rtl/asb_presc.v
// Purpose: Converter clock prescaler, one-cycle enable pulse per converter clock
// Assumes: Stopped and cleared through run_i while the converter is disabled
// Notes:   Division factor is two to the power of (sel+1)
`timescale 1ns/10ps
`default_nettype none
module asb_presc (
  input  wire       clk_i,     // System clock
  input  wire       rst_i,     // Asynchronous reset, active high
  input  wire       run_i,     // Prescaler runs while high
  input  wire [2:0] sel_i,     // Division select
  output reg        tick_o     // One-cycle converter clock edge
);
  reg [7:0] cnt_q;             // Free counter
  wire [7:0] mask;             // Terminal count mask

  assign mask = (8'h02 << sel_i) - 8'h01;

  // Count and pulse; cleared continuously while stopped
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      tick_o <= ((cnt_q & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// ### rtl/asb_ctrl.v
// Purpose: Selection buffer, conversion sequencer and sleep start for the converter
// Assumes: Analog core modelled by a sampled input; CPU on Wishbone classic
// Notes:   Applied selection tracks the temporary copy except while locked
`timescale 1ns/10ps
`default_nettype none
`include "asb_consts.vh"
// Functional notes
// RULE_01 - Temporary selection register, freely read and written
// RULE_02 - Idle: applied selection follows temporary copy
// RULE_03 - Conversion start freezes applied selection
// RULE_04 - Release lock in last converter clock
// RULE_05 - Start waits for next converter clock edge
// RULE_06 - Software waits one converter clock after start
// RULE_07 - Auto trigger: change selection only when safe
// RULE_08 - Differential channel change needs 125 us settle
// RULE_09 - Reference change needs same settle time
// RULE_10 - Single mode: select channel before starting
// RULE_11 - Free running: select before first conversion
// RULE_12 - Free run next result uses old selection
// RULE_13 - Discard first differential result after switch
// RULE_14 - Discard first result after reference switch
// RULE_15 - Overrange single-ended input saturates at maximum
// RULE_16 - Idle or noise sleep starts conversion
// RULE_17 - Completion raises interrupt request even after wake
// RULE_18 - Other sleep states leave converter enabled
// RULE_19 - Software toggles enable after deep sleep
// RULE_20 - Completion stores result, sets flag, clears start
// RULE_21 - Reference code: external, supply, 1.1V, 2.56V
// RULE_22 - Start bit reads one throughout conversion
// RULE_23 - Lock set at start edge, freed one early
// RULE_24 - CPU reads return temporary selection contents
module asb_ctrl (
  input  wire        CLK_SYS_I,      // System clock, 50 MHz
  input  wire        RST_I,          // Asynchronous reset, active high
  input  wire        WB_CYC_I,       // Wishbone cycle
  input  wire        WB_STB_I,       // Wishbone strobe
  input  wire        WB_WE_I,        // Wishbone write enable
  input  wire [3:0]  WB_ADR_I,       // Wishbone byte address
  input  wire [3:0]  WB_SEL_I,       // Wishbone byte enables
  input  wire [31:0] WB_DAT_I,       // Wishbone write data
  output reg  [31:0] WB_DAT_O,       // Wishbone read data
  output reg         WB_ACK_O,       // Wishbone acknowledge
  output reg         WB_ERR_O,       // Wishbone error on unmapped address
  input  wire [10:0] SAMPLE_I,       // Analog core code, bit 10 flags overrange
  input  wire        SLEEP_I,        // CPU halted in sleep, from another domain
  input  wire [2:0]  SLEEP_MODE_I,   // Sleep state code, same domain as SLEEP_I
  input  wire        TRIGGER_I,      // Auto trigger source, asynchronous
  output reg  [4:0]  CHAN_SEL_O,     // Applied channel and gain selection
  output reg  [1:0]  REF_SEL_O,      // Applied reference selection
  output reg         SAMPLE_HOLD_O,  // Sample and hold strobe to analog core
  output reg         IRQ_O           // Completion interrupt request
);
  localparam ST_IDLE = 2'b00;        // Waiting for start
  localparam ST_ARM  = 2'b01;        // Start requested, wait for converter clock
  localparam ST_CONV = 2'b10;        // Converting

  reg [4:0]  chan_tmp_q;             // Temporary channel selection
  reg [1:0]  ref_tmp_q;              // Temporary reference selection
  reg        en_q;                   // Converter enable
  reg        auto_q;                 // Auto trigger enable
  reg        ie_q;                   // Completion interrupt enable
  reg        flag_q;                 // Conversion complete flag
  reg        start_q;                // Start bit, high through conversion
  reg [2:0]  pre_q;                  // Prescaler select
  reg [9:0]  result_q;               // Last result
  reg        lock_q;                 // Applied selection frozen
  reg        first_q;                // Next conversion is the extended one
  reg [1:0]  state_q;                // Sequencer state
  reg [4:0]  cnt_q;                  // Converter clocks left
  reg        slp_m_q, slp_q, slp_d_q; // Sleep synchroniser and history
  reg        trg_m_q, trg_q, trg_d_q; // Trigger synchroniser and history
  reg [2:0]  mode_m_q, mode_q;       // Sleep mode synchroniser
  wire       tick;                   // Converter clock edge
  wire       req;                    // Bus request this cycle
  wire       wr;                     // Bus write this cycle
  wire       hit_sel, hit_ctl, hit_res, hit_app;
  wire       sleep_start;            // Halted in qualifying sleep
  wire       trig_edge;              // Rising trigger edge
  wire       done;                   // Last converter clock of conversion
  wire       sw_start;               // Software writes one to start bit
  wire       cpu_clr_flag;           // Software writes one to clear flag

  // Write data merged with byte lane zero enable
  function [7:0] lane0;
    input [3:0] sel;
    input [7:0] old;
    input [7:0] nw;
    begin
      lane0 = sel[0] ? nw : old;
    end
  endfunction

  asb_presc u_presc (
    .clk_i  (CLK_SYS_I),
    .rst_i  (RST_I),
    .run_i  (en_q),
    .sel_i  (pre_q),
    .tick_o (tick)
  );

  assign req     = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign wr      = req && WB_WE_I;
  assign hit_sel = (WB_ADR_I == `ASB_OFS_SEL);
  assign hit_ctl = (WB_ADR_I == `ASB_OFS_CTRL);
  assign hit_res = (WB_ADR_I == `ASB_OFS_RESULT);
  assign hit_app = (WB_ADR_I == `ASB_OFS_APPLIED);
  assign sw_start     = wr && hit_ctl && WB_SEL_I[0] && WB_DAT_I[`ASB_CTL_START];
  assign cpu_clr_flag = wr && hit_ctl && WB_SEL_I[0] && WB_DAT_I[`ASB_CTL_FLAG];
  // Noise sleep or idle sleep, rising halt, enabled, idle, single mode, irq on
  assign sleep_start = slp_q && !slp_d_q && en_q && !start_q && !auto_q && ie_q &&
                       ((mode_q == `ASB_SLEEP_IDLE) || (mode_q == `ASB_SLEEP_NOISE)); // RULE_16
  // Other sleep modes fall through: enable is never cleared by hardware
  assign trig_edge = trg_q && !trg_d_q && auto_q && en_q; // RULE_07
  assign done      = (state_q == ST_CONV) && tick && (cnt_q == 5'h01);

  // Synchronisers for pins from outside the clock domain
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      slp_m_q  <= 1'b0;
      slp_q    <= 1'b0;
      slp_d_q  <= 1'b0;
      trg_m_q  <= 1'b0;
      trg_q    <= 1'b0;
      trg_d_q  <= 1'b0;
      mode_m_q <= 3'h0;
      mode_q   <= 3'h0;
    end else begin
      slp_m_q  <= SLEEP_I;
      slp_q    <= slp_m_q;
      slp_d_q  <= slp_q;
      trg_m_q  <= TRIGGER_I;
      trg_q    <= trg_m_q;
      trg_d_q  <= trg_q;
      mode_m_q <= SLEEP_MODE_I;
      mode_q   <= mode_m_q;
    end
  end

  // Wishbone slave: one wait-free answer, error on unmapped address
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req && (hit_sel || hit_ctl || hit_res || hit_app);
      WB_ERR_O <= req && !(hit_sel || hit_ctl || hit_res || hit_app);
      WB_DAT_O <= 32'h00000000;
      if (req && !WB_WE_I) begin
        if (hit_sel) begin
          // Reads always show the temporary copy
          WB_DAT_O <= {24'h000000, ref_tmp_q, 1'b0, chan_tmp_q}; // RULE_24
        end else if (hit_ctl) begin
          WB_DAT_O <= {21'h000000, pre_q, 3'h0, ie_q, flag_q, auto_q,
                       start_q, en_q}; // RULE_22
        end else if (hit_res) begin
          WB_DAT_O <= {22'h000000, result_q};
        end else if (hit_app) begin
          WB_DAT_O <= {23'h000000, lock_q, REF_SEL_O, 1'b0, CHAN_SEL_O};
        end
      end
    end
  end

  // Temporary selection, written freely by the CPU
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      chan_tmp_q <= 5'h00;
      ref_tmp_q  <= `ASB_REF_EXT;
    end else if (wr && hit_sel && WB_SEL_I[0]) begin
      chan_tmp_q <= WB_DAT_I[`ASB_CHAN_MSB:`ASB_CHAN_LSB]; // RULE_01
      ref_tmp_q  <= WB_DAT_I[`ASB_REF_MSB:`ASB_REF_LSB]; // RULE_21
    end
  end

  // Applied selection copies the temporary one unless locked
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      CHAN_SEL_O <= 5'h00;
      REF_SEL_O  <= `ASB_REF_EXT;
    end else if (!lock_q) begin
      CHAN_SEL_O <= chan_tmp_q; // RULE_02
      REF_SEL_O  <= ref_tmp_q;
    end
  end

  // Control register fields written by software
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      en_q   <= 1'b0;
      auto_q <= 1'b0;
      ie_q   <= 1'b0;
      pre_q  <= 3'h0;
    end else if (wr && hit_ctl) begin
      if (WB_SEL_I[0]) begin
        en_q   <= WB_DAT_I[`ASB_CTL_EN];
        auto_q <= WB_DAT_I[`ASB_CTL_AUTO];
        ie_q   <= WB_DAT_I[`ASB_CTL_IE];
      end
      if (WB_SEL_I[1]) begin
        pre_q <= WB_DAT_I[`ASB_CTL_PRE_MSB:`ASB_CTL_PRE_LSB];
      end
    end
  end

  // Sequencer: arm on request, start on converter clock, count down
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_q       <= ST_IDLE;
      cnt_q         <= 5'h00;
      lock_q        <= 1'b0;
      start_q       <= 1'b0;
      first_q       <= 1'b1;
      SAMPLE_HOLD_O <= 1'b0;
    end else begin
      SAMPLE_HOLD_O <= 1'b0;
      if (!en_q) begin
        // Disabling aborts and forces an extended next conversion
        state_q <= ST_IDLE;
        lock_q  <= 1'b0;
        start_q <= 1'b0;
        first_q <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (sw_start || sleep_start || trig_edge) begin
              start_q <= 1'b1; // RULE_22
              state_q <= ST_ARM;
            end
          end
          ST_ARM: begin
            // Waiting for the converter clock, not the write itself
            if (tick) begin
              state_q <= ST_CONV; // RULE_05
              lock_q  <= 1'b1; // RULE_03 RULE_23
              cnt_q   <= first_q ? `ASB_FIRST_CYC : `ASB_NORMAL_CYC;
              first_q <= 1'b0;
              SAMPLE_HOLD_O <= 1'b1;
            end
          end
          ST_CONV: begin
            if (tick) begin
              cnt_q <= cnt_q - 5'h01;
              if (cnt_q == 5'h02) begin
                lock_q <= 1'b0; // RULE_04 RULE_23
              end
              if (done) begin
                if (auto_q && flag_q == 1'b0) begin
                  // Free run: next conversion locks current applied value
                  state_q <= ST_ARM; // RULE_12
                end else begin
                  state_q <= ST_IDLE;
                  start_q <= 1'b0; // RULE_20
                end
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Result capture with overrange saturation
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      result_q <= 10'h000;
    end else if (done) begin
      result_q <= SAMPLE_I[10] ? `ASB_RES_MAX : SAMPLE_I[9:0]; // RULE_15 RULE_20
    end
  end

  // Completion flag, set wins over software clear
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1; // RULE_20
    end else if (cpu_clr_flag) begin
      flag_q <= 1'b0;
    end
  end

  // Interrupt request, independent of any earlier wake; completion beats a clear
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= ie_q && (done || (flag_q && !cpu_clr_flag)); // RULE_17
    end
  end
endmodule
`default_nettype wire

// ### bench/asb_ctrl_assertions.sv
// Purpose: Bus timing, pulse and selection lock checks at the controller ports
// Assumes: Single clock domain, asynchronous active-high reset
// Notes:   Read-back of the selection is judged against a shadow of bus writes
`timescale 1ns/10ps
`default_nettype none
module asb_ctrl_assertions (
  input wire logic        CLK_SYS_I,     // System clock
  input wire logic        RST_I,         // Reset, active high
  input wire logic        WB_CYC_I,      // Bus cycle
  input wire logic        WB_STB_I,      // Bus strobe
  input wire logic        WB_WE_I,       // Write enable
  input wire logic [3:0]  WB_ADR_I,      // Byte address
  input wire logic [3:0]  WB_SEL_I,      // Byte enables
  input wire logic [31:0] WB_DAT_I,      // Write data
  input wire logic [31:0] WB_DAT_O,      // Read data
  input wire logic        WB_ACK_O,      // Acknowledge
  input wire logic        WB_ERR_O,      // Error
  input wire logic [4:0]  CHAN_SEL_O,    // Applied channel
  input wire logic [1:0]  REF_SEL_O,     // Applied reference
  input wire logic        SAMPLE_HOLD_O, // Conversion start strobe
  input wire logic        IRQ_O          // Interrupt request
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [7:0] shadow_q;  // Last selection byte written by software
  // Shadow follows only completed writes to lane 0 of the selection word
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      shadow_q <= 8'h00;
    end else if (WB_ACK_O && WB_WE_I && WB_ADR_I == 4'h0 && WB_SEL_I[0]) begin
      shadow_q <= WB_DAT_I[7:0];
    end
  end
  property p_ans; $rose(WB_STB_I) && WB_CYC_I |=> WB_ACK_O || WB_ERR_O; endproperty
  a_ans: assert property (p_ans) else $error("No answer one cycle after request");
  property p_err; $rose(WB_STB_I) && WB_CYC_I && WB_ADR_I[1:0] != 2'h0 |=> WB_ERR_O && !WB_ACK_O;
  endproperty
  a_err: assert property (p_err) else $error("Unaligned address not refused");
  property p_map; $rose(WB_STB_I) && WB_CYC_I && WB_ADR_I[1:0] == 2'h0 |=> WB_ACK_O && !WB_ERR_O;
  endproperty
  a_map: assert property (p_map) else $error("Mapped address not acknowledged");
  property p_pulse; WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O; endproperty
  a_pulse: assert property (p_pulse) else $error("Answer held longer than one cycle");
  property p_dat; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("Read data not zero outside ack");
  property p_sh; SAMPLE_HOLD_O |=> !SAMPLE_HOLD_O; endproperty
  a_sh: assert property (p_sh) else $error("Sample strobe wider than one cycle");
  // Lock holds far longer than ten cycles at the fastest prescaler setting
  property p_lock; SAMPLE_HOLD_O |-> ##2 ($stable(CHAN_SEL_O) && $stable(REF_SEL_O)) [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("Applied selection moved while locked");
  property p_rdsel; WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h0 |-> WB_DAT_O[7:0] == (shadow_q & 8'hDF);
  endproperty
  a_rdsel: assert property (p_rdsel) else $error("Selection read-back differs");
  c_conv: cover property (SAMPLE_HOLD_O);
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (WB_ERR_O);
endmodule
bind asb_ctrl asb_ctrl_assertions asb_ctrl_assertions_inst (.CLK_SYS_I, .RST_I, .WB_CYC_I,
  .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O,
  .CHAN_SEL_O, .REF_SEL_O, .SAMPLE_HOLD_O, .IRQ_O);
`default_nettype wire

// ### bench/adc_select_buffer_sleep_ctrl_bench.sv
// Purpose: Directed checks of selection buffering, conversions and sleep start
// Assumes: Prescaler field left at zero, so a converter clock is two cycles
// Notes:   One triggered free-running pair; sleep results are never judged
`timescale 1ns/10ps
`default_nettype none
`include "asb_consts.vh"
module adc_select_buffer_sleep_ctrl_bench;
  // Gain stage settling span in system clocks, 50 per microsecond
  localparam integer SETTLE_CYC = `ASB_SETTLE_US * 50;
  logic clk, rst, cyc, stb, we, ack, err, sh, irq, slp, trig, werr;
  logic [3:0] adr, sel;
  logic [31:0] dat, rdat, q;
  logic [10:0] smp;         // Analog code fed to the core
  logic [2:0] mode;         // Sleep state code
  logic [4:0] chan;         // Applied channel seen at the pins
  logic [1:0] refs;         // Applied reference seen at the pins
  integer miscompares, cmp_count, n, r;
  asb_ctrl asb_ctrl_inst (.CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .SAMPLE_I(smp), .SLEEP_I(slp), .SLEEP_MODE_I(mode),
    .TRIGGER_I(trig), .CHAN_SEL_O(chan), .REF_SEL_O(refs), .SAMPLE_HOLD_O(sh), .IRQ_O(irq));
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Classic single cycle; held until ack or err is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer k;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
    q = rdat;
    werr = err;
    if (k >= 50) miscompares++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic t_reset;
    wb(1'b0, 4'h0, 32'h0); chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0); chk(q, 32'h0);
    wb(1'b0, 4'hC, 32'h0); chk(q, 32'h0);
    wb(1'b0, 4'h2, 32'h0); chk(32'(werr), 32'h1);
    $display("Test reset done");
  endtask
  task automatic t_track;
    wb(1'b1, 4'h4, 32'h1);
    for (r = 0; r < 4; r++) begin
      wb(1'b1, 4'h0, {24'h0, r[1:0], 1'b0, 5'(r * 5 + 3)});
      wb(1'b0, 4'h0, 32'h0); chk(q, {24'h0, r[1:0], 1'b0, 5'(r * 5 + 3)});
      chk(32'(refs), 32'(r));
      chk(32'(chan), 32'(r * 5 + 3));
    end
    $display("Test track done");
  endtask
  // Start with channel 3, rewrite to 9 with reference 3 mid-conversion
  task automatic t_conv(input logic [10:0] s, input logic [9:0] e);
    smp <= s;
    wb(1'b1, 4'h0, 32'h3);
    // Let the gain stage settle on the new choice before starting
    repeat (SETTLE_CYC) @(posedge clk);
    wb(1'b1, 4'h4, 32'h3);
    repeat (4) @(posedge clk);
    wb(1'b1, 4'h0, 32'hC9);
    wb(1'b0, 4'h4, 32'h0); chk(32'(q[1]), 32'h1);
    wb(1'b0, 4'hC, 32'h0); chk(32'(q[8:0]), 32'h103);
    chk(32'(chan), 32'h3);
    wb(1'b0, 4'h0, 32'h0); chk(q, 32'hC9);
    n = 0;
    do begin
      wb(1'b0, 4'h4, 32'h0);
      n++;
    end while (q[3] !== 1'b1 && n < 100);
    chk(32'(q[1]), 32'h0);
    chk(32'({refs, chan}), 32'h69);
    wb(1'b0, 4'h8, 32'h0); chk(q, 32'(e));
    wb(1'b1, 4'h4, 32'h9);
    $display("Test conversion done");
  endtask
  // Sleep codes 0 and 1 start a conversion; code 2 leaves the block alone
  task automatic t_sleep;
    for (r = 0; r < 3; r++) begin
      // Results after the switch to reference 3 are discarded, never judged
      wb(1'b1, 4'h4, 32'h19);
      mode <= r[2:0];
      slp <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
        @(posedge clk);
        n++;
        // Second pass wakes early; the request must still come at completion
        if (r == 1 && n == 10) slp <= 1'b0;
      end
      chk(32'(irq), 32'(r < 2));
      slp <= 1'b0;
      wb(1'b0, 4'h4, 32'h0); chk(32'(q[0]), 32'h1);
    end
    // Converter stayed on through the other sleep; cycle it for an extended start
    wb(1'b1, 4'h4, 32'h0);
    wb(1'b1, 4'h4, 32'h1);
    $display("Test sleep done");
  endtask
  // Trigger starts a free-running pair; a change in the second waits its turn
  task automatic t_auto;
    wb(1'b1, 4'h0, 32'h2);
    wb(1'b1, 4'h4, 32'hD);
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    trig <= 1'b0;
    wb(1'b1, 4'h0, 32'h45);
    wb(1'b0, 4'hC, 32'h0); chk(32'(q[8:0]), 32'h102);
    n = 0;
    do begin
      wb(1'b0, 4'h4, 32'h0);
      n++;
    end while (q[3] !== 1'b1 && n < 100);
    chk(32'(q[1]), 32'h1);
    wb(1'b1, 4'h0, 32'h7);
    wb(1'b0, 4'hC, 32'h0); chk(32'(q[8:0]), 32'h145);
    n = 0;
    do begin
      wb(1'b0, 4'h4, 32'h0);
      n++;
    end while (q[1] !== 1'b0 && n < 100);
    chk(32'({refs, chan}), 32'h07);
    wb(1'b1, 4'h4, 32'h9);
    $display("Test auto trigger done");
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; dat = 0;
    smp = 0; slp = 0; mode = 0; trig = 0; miscompares = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_track;
    t_conv(11'h7FF, 10'h3FF);
    t_conv(11'h155, 10'h155);
    t_sleep;
    t_auto;
    tally_and_finish;
  end
  // Hang guard, well past the expected run length
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
